//--- src/srf_pkg.sv
// Constants and types for the receive FIFO with stop/resume flow control.
// Assumes one 100 MHz clock; serial framing is done by a neighbouring UART.
// Function
// - Received characters held in a 253-entry FIFO, read in arrival order.
// - Occupancy reaching 100 sends the stop code 023 octal to the host.
// - After a stop, draining to 50 sends the resume code 021 octal.
// - With 253 stored, further received characters are dropped.
// - Overflow inserts no marker character into the display stream.
// - Thresholds apply at every line rate up to 19200 baud.
// - Reset or self-test empties the receive buffer.
// - Resume sent only after reset or self-test ends, if flow control enabled.
// - Stop and resume codes always honoured; while stopped only they are sent.
// - While held, up to 253 keystroke codes are queued and sent on resume.
// - Keystroke queue overflow stops key-click feedback.
// - Entering or leaving setup flushes keystrokes and clears keyboard lock.
// - One stop bit per character, two at 110 baud.
// - Seven data bits, least significant bit first.
package srf_pkg;
  localparam int DEPTH = 253;
  localparam int PTR_W = 8;
  localparam int CNT_W = 9;
  // Seven-bit words; start and stop bits are stripped by the UART
  localparam int DATA_W = 7;
  localparam logic [CNT_W-1:0] STOP_LEVEL = 9'h064;
  localparam logic [CNT_W-1:0] RESUME_LEVEL = 9'h032;
  localparam logic [CNT_W-1:0] FULL_LEVEL = 9'h0FD;
  localparam logic [DATA_W-1:0] CODE_STOP = 7'h13;
  localparam logic [DATA_W-1:0] CODE_RESUME = 7'h11;
  localparam logic [PTR_W-1:0] PTR_LAST = 8'hFC;

  typedef enum logic [2:0] {
    SRF_FLOW_GO = 3'b001,
    SRF_FLOW_HELD = 3'b010,
    SRF_FLOW_INIT = 3'b100
  } srf_flow_t;
endpackage

//--- src/srf_skid.sv
// Two-entry buffer between the code selector and the transmitter.
// Assumes same-clock source and sink with valid/ready signalling.
`timescale 1ns/10ps
module srf_skid (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic [srf_pkg::DATA_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [srf_pkg::DATA_W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [srf_pkg::DATA_W-1:0] slot_reg [2];
  logic [srf_pkg::DATA_W-1:0] slot_next [2];
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;

  // ---------------------------------------------
  // Next state: shift out of slot 0, fill behind
  // ---------------------------------------------
  always_comb begin
    logic pop;
    logic push;
    pop = out_valid && out_ready;
    push = in_valid && in_ready;
    slot_next = slot_reg;
    cnt_next = cnt_reg;
    if (pop) begin
      slot_next[0] = slot_reg[1];
    end
    if (push) begin
      if (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop)) begin
        slot_next[0] = in_data;
      end else begin
        slot_next[1] = in_data;
      end
    end
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    if (flush) begin
      cnt_next = 2'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      slot_reg[0] <= '0;
      slot_reg[1] <= '0;
      cnt_reg <= 2'h0;
    end else begin
      slot_reg <= slot_next;
      cnt_reg <= cnt_next;
    end
  end

  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = slot_reg[0];
endmodule

//--- src/srf_top.sv
// Receive FIFO, stop/resume flow control and held keystroke queue.
// Assumes a UART on the same clock delivers 7-bit words as one-cycle
// strobes and takes transmit words with valid/ready.
`timescale 1ns/10ps
module srf_top (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [srf_pkg::DATA_W-1:0] rx_data,
  input wire logic rx_strobe,
  input wire logic [srf_pkg::DATA_W-1:0] key_data,
  input wire logic key_valid,
  input wire logic reinit_start,
  input wire logic reinit_done,
  input wire logic flow_enable,
  input wire logic setup_toggle,
  input wire logic disp_ready,
  output logic [srf_pkg::DATA_W-1:0] disp_data,
  output logic disp_valid,
  output logic [srf_pkg::DATA_W-1:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic click_enable,
  output logic kbd_locked,
  output logic [srf_pkg::CNT_W-1:0] rx_level
);
  // -----------------------------
  // Storage and state
  // -----------------------------
  logic [srf_pkg::DATA_W-1:0] rx_mem [srf_pkg::DEPTH];
  logic [srf_pkg::DATA_W-1:0] key_mem [srf_pkg::DEPTH];
  logic [srf_pkg::PTR_W-1:0] rx_wr_reg, rx_wr_next, rx_rd_reg, rx_rd_next;
  logic [srf_pkg::CNT_W-1:0] rx_cnt_reg, rx_cnt_next;
  logic [srf_pkg::PTR_W-1:0] kq_wr_reg, kq_wr_next, kq_rd_reg, kq_rd_next;
  logic [srf_pkg::CNT_W-1:0] kq_cnt_reg, kq_cnt_next;
  logic [srf_pkg::DATA_W-1:0] disp_reg, disp_next, tx_reg, tx_next;
  logic disp_v_reg, disp_v_next, tx_v_reg, tx_v_next;
  logic stop_sent_reg, stop_sent_next, held_reg, held_next;
  logic pend_stop_reg, pend_stop_next, pend_res_reg, pend_res_next;
  logic click_reg, click_next, lock_reg, lock_next;
  srf_pkg::srf_flow_t init_reg, init_next;
  logic rx_push, rx_pop, kq_push, kq_pop;
  logic sk_in_valid, sk_in_ready, sk_out_valid;
  logic [srf_pkg::DATA_W-1:0] sk_in_data, sk_out_data;
  logic is_stop, is_resume, send_code, ctrl_code;

  // Incoming stop/resume codes act on transmission, not stored
  assign is_stop = rx_strobe && rx_data == srf_pkg::CODE_STOP;
  assign is_resume = rx_strobe && rx_data == srf_pkg::CODE_RESUME;

  // Full buffer drops the character silently; no marker is inserted
  assign rx_push = rx_strobe && !is_stop && !is_resume
    && rx_cnt_reg != srf_pkg::FULL_LEVEL && init_reg != srf_pkg::SRF_FLOW_INIT;
  // Display pops only when its output slot is free or being taken
  assign rx_pop = rx_cnt_reg != '0 && (!disp_v_reg || disp_ready);

  // Codes take priority into the skid buffer; keys only when not held
  assign ctrl_code = pend_stop_reg || pend_res_reg;
  assign send_code = ctrl_code && sk_in_ready;
  assign kq_pop = !ctrl_code && !held_reg && kq_cnt_reg != '0 && sk_in_ready;
  assign kq_push = key_valid && kq_cnt_reg != srf_pkg::FULL_LEVEL;
  assign sk_in_valid = ctrl_code || kq_pop;
  assign sk_in_data = pend_stop_reg ? srf_pkg::CODE_STOP
    : (pend_res_reg ? srf_pkg::CODE_RESUME : key_mem[kq_rd_reg]);

  // ------------------------------------------------
  // Receive FIFO pointers and count
  // ------------------------------------------------
  always_comb begin
    rx_wr_next = rx_wr_reg;
    rx_rd_next = rx_rd_reg;
    rx_cnt_next = rx_cnt_reg;
    if (rx_push) begin
      rx_wr_next = (rx_wr_reg == srf_pkg::PTR_LAST) ? '0 : rx_wr_reg + 8'h01;
    end
    if (rx_pop) begin
      rx_rd_next = (rx_rd_reg == srf_pkg::PTR_LAST) ? '0 : rx_rd_reg + 8'h01;
    end
    rx_cnt_next = rx_cnt_reg + {8'h00, rx_push} - {8'h00, rx_pop};
    if (reinit_start) begin
      rx_wr_next = '0;
      rx_rd_next = '0;
      rx_cnt_next = '0;
    end
  end

  // ------------------------------------------------
  // Display output slot
  // ------------------------------------------------
  always_comb begin
    disp_next = disp_reg;
    disp_v_next = disp_v_reg && !disp_ready;
    if (rx_pop) begin
      disp_next = rx_mem[rx_rd_reg];
      disp_v_next = 1'b1;
    end
    if (reinit_start) begin
      disp_v_next = 1'b0;
    end
  end

  // ------------------------------------------------
  // Flow control: thresholds apply regardless of baud
  // ------------------------------------------------
  always_comb begin
    stop_sent_next = stop_sent_reg;
    pend_stop_next = pend_stop_reg;
    pend_res_next = pend_res_reg;
    init_next = init_reg;
    if (send_code) begin
      pend_stop_next = 1'b0;
      if (!pend_stop_reg) begin
        pend_res_next = 1'b0;
      end
    end
    // One stop per upward crossing, resume only after a stop
    if (flow_enable && !stop_sent_reg && rx_cnt_next >= srf_pkg::STOP_LEVEL) begin
      stop_sent_next = 1'b1;
      pend_stop_next = 1'b1;
      pend_res_next = 1'b0;
    end else if (stop_sent_reg && rx_cnt_next <= srf_pkg::RESUME_LEVEL) begin
      stop_sent_next = 1'b0;
      pend_res_next = flow_enable;
    end
    case (init_reg)
      srf_pkg::SRF_FLOW_INIT: begin
        if (reinit_done) begin
          init_next = srf_pkg::SRF_FLOW_GO;
          pend_res_next = flow_enable;
        end
      end
      default: begin
        init_next = srf_pkg::SRF_FLOW_GO;
      end
    endcase
    if (reinit_start) begin
      init_next = srf_pkg::SRF_FLOW_INIT;
      stop_sent_next = 1'b0;
      pend_stop_next = 1'b0;
      pend_res_next = 1'b0;
    end
  end

  // ------------------------------------------------
  // Transmit hold, keystroke queue, click and lock
  // ------------------------------------------------
  always_comb begin
    held_next = held_reg;
    kq_wr_next = kq_wr_reg;
    kq_rd_next = kq_rd_reg;
    click_next = click_reg;
    lock_next = lock_reg;
    if (is_stop) begin
      held_next = 1'b1;
    end else if (is_resume) begin
      held_next = 1'b0;
    end
    if (kq_push) begin
      kq_wr_next = (kq_wr_reg == srf_pkg::PTR_LAST) ? '0 : kq_wr_reg + 8'h01;
    end
    if (kq_pop) begin
      kq_rd_next = (kq_rd_reg == srf_pkg::PTR_LAST) ? '0 : kq_rd_reg + 8'h01;
    end
    kq_cnt_next = kq_cnt_reg + {8'h00, kq_push} - {8'h00, kq_pop};
    // Overflow silences clicks and locks the keyboard until setup
    if (key_valid && !kq_push) begin
      click_next = 1'b0;
      lock_next = 1'b1;
    end
    if (setup_toggle) begin
      kq_wr_next = '0;
      kq_rd_next = '0;
      kq_cnt_next = '0;
      click_next = 1'b1;
      lock_next = 1'b0;
    end
  end

  // ------------------------------------------------
  // Transmit output slot fed by the skid buffer
  // ------------------------------------------------
  always_comb begin
    tx_next = tx_reg;
    tx_v_next = tx_v_reg && !tx_ready;
    if (sk_out_valid && (!tx_v_reg || tx_ready)) begin
      tx_next = sk_out_data;
      tx_v_next = 1'b1;
    end
  end

  // Memories have no reset; pointers bound what is read
  always_ff @(posedge sys_clk) begin
    if (rx_push) begin
      rx_mem[rx_wr_reg] <= rx_data;
    end
    if (kq_push) begin
      key_mem[kq_wr_reg] <= key_data;
    end
  end

  // ------------------------------------------------
  // State registers
  // ------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rx_wr_reg <= '0;
      rx_rd_reg <= '0;
      rx_cnt_reg <= '0;
      kq_wr_reg <= '0;
      kq_rd_reg <= '0;
      kq_cnt_reg <= '0;
      disp_reg <= '0;
      disp_v_reg <= 1'b0;
      tx_reg <= '0;
      tx_v_reg <= 1'b0;
      stop_sent_reg <= 1'b0;
      held_reg <= 1'b0;
      pend_stop_reg <= 1'b0;
      pend_res_reg <= 1'b0;
      click_reg <= 1'b1;
      lock_reg <= 1'b0;
      init_reg <= srf_pkg::SRF_FLOW_GO;
    end else begin
      rx_wr_reg <= rx_wr_next;
      rx_rd_reg <= rx_rd_next;
      rx_cnt_reg <= rx_cnt_next;
      kq_wr_reg <= kq_wr_next;
      kq_rd_reg <= kq_rd_next;
      kq_cnt_reg <= kq_cnt_next;
      disp_reg <= disp_next;
      disp_v_reg <= disp_v_next;
      tx_reg <= tx_next;
      tx_v_reg <= tx_v_next;
      stop_sent_reg <= stop_sent_next;
      held_reg <= held_next;
      pend_stop_reg <= pend_stop_next;
      pend_res_reg <= pend_res_next;
      click_reg <= click_next;
      lock_reg <= lock_next;
      init_reg <= init_next;
    end
  end

  srf_skid u_skid (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .flush(setup_toggle),
    .in_data(sk_in_data),
    .in_valid(sk_in_valid),
    .in_ready(sk_in_ready),
    .out_data(sk_out_data),
    .out_valid(sk_out_valid),
    .out_ready(!tx_v_reg || tx_ready)
  );

  assign disp_data = disp_reg;
  assign disp_valid = disp_v_reg;
  assign tx_data = tx_reg;
  assign tx_valid = tx_v_reg;
  assign click_enable = click_reg;
  assign kbd_locked = lock_reg;
  assign rx_level = rx_cnt_reg;
endmodule

//--- verification/srf_top_assertions.sv
// Concurrent checks on the receive FIFO and flow control top ports.
// Assumes a bind from the bench; one clock, synchronous active-low reset.
`timescale 1ns/10ps
module srf_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [srf_pkg::DATA_W-1:0] rx_data,
  input wire logic rx_strobe,
  input wire logic reinit_start,
  input wire logic flow_enable,
  input wire logic setup_toggle,
  input wire logic disp_ready,
  input wire logic [srf_pkg::DATA_W-1:0] disp_data,
  input wire logic disp_valid,
  input wire logic [srf_pkg::DATA_W-1:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic click_enable,
  input wire logic kbd_locked,
  input wire logic [srf_pkg::CNT_W-1:0] rx_level
);
  localparam logic [6:0] CS = srf_pkg::CODE_STOP;
  localparam logic [6:0] CR = srf_pkg::CODE_RESUME;
  localparam logic [8:0] LS = srf_pkg::STOP_LEVEL;
  localparam logic [8:0] LR = srf_pkg::RESUME_LEVEL;
  logic held_reg;
  logic sent_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Host stop state, and a stop code that still awaits its resume
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      held_reg <= 1'b0;
      sent_reg <= 1'b0;
    end else begin
      if (rx_strobe && rx_data == CS)
        held_reg <= 1'b1;
      else if (rx_strobe && rx_data == CR)
        held_reg <= 1'b0;
      if (tx_valid && tx_ready && tx_data == CS)
        sent_reg <= 1'b1;
      else if (tx_valid && tx_ready && tx_data == CR)
        sent_reg <= 1'b0;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_stop_on_fill: assert property (
    flow_enable && rx_level == LS && $past(rx_level) == LS - 9'h001
    |-> ##[1:20] (tx_valid && tx_data == CS)) else $error("stop code missing");
  a_resume_on_drain: assert property (
    sent_reg && rx_level == LR && $past(rx_level) == LR + 9'h001
    |-> ##[1:20] (tx_valid && tx_data == CR)) else $error("resume code missing");
  a_level_cap: assert property (
    rx_level <= srf_pkg::FULL_LEVEL) else $error("occupancy above capacity");
  a_code_unstored: assert property (
    rx_strobe && (rx_data == CS || rx_data == CR)
    |=> rx_level <= $past(rx_level)) else $error("flow code stored");
  a_reinit_empty: assert property (
    reinit_start |=> rx_level == 9'h000 && !disp_valid) else $error("buffer kept");
  a_held_codes: assert property (
    held_reg && $rose(tx_valid) |-> (tx_data == CS || tx_data == CR))
    else $error("word sent while held");
  a_lock_click: assert property (
    kbd_locked |-> !click_enable) else $error("click on while locked");
  a_setup_clear: assert property (
    setup_toggle |=> !kbd_locked && click_enable) else $error("setup left lock");
  a_disp_stand: assert property (
    disp_valid && !disp_ready && !reinit_start |=> disp_valid && $stable(disp_data))
    else $error("display word dropped");
  // Main scenarios reached
  c_stop: cover property (tx_valid && tx_ready && tx_data == CS);
  c_resume: cover property (tx_valid && tx_ready && tx_data == CR);
  c_lock: cover property ($rose(kbd_locked));
endmodule

//--- verification/srf_host.sv
// Host computer model on the far side of the serial line.
// Assumes framed words on the shared clock; bench drives the receive side.
`timescale 1ns/10ps
module srf_host (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [srf_pkg::DATA_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic slow,
  input wire logic reinit_cmd,
  output logic held
);
  int n_stop;
  int n_resume;
  logic [srf_pkg::DATA_W-1:0] keys[$];
  logic pace_reg;
  // Slow host takes a word only every other cycle
  // Host always runs flow control, so no rate limit or bad rate pair arises
  assign tx_ready = slow ? pace_reg : 1'b1;
  // Count codes, keep keys in order, follow the stop state
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      pace_reg <= 1'b0;
      held <= 1'b0;
      n_stop <= 0;
      n_resume <= 0;
    end else begin
      pace_reg <= ~pace_reg;
      if (reinit_cmd)
        held <= 1'b1;
      if (tx_valid && tx_ready) begin
        if (tx_data === srf_pkg::CODE_STOP) begin
          n_stop <= n_stop + 1;
          held <= 1'b1;
        end else if (tx_data === srf_pkg::CODE_RESUME) begin
          n_resume <= n_resume + 1;
          held <= 1'b0;
        end else
          keys.push_back(tx_data);
      end
    end
  end
endmodule

//--- verification/testbench.sv
// Self-checking bench for the receive FIFO with stop/resume flow control.
// Assumes srf_pkg, the design, srf_host and srf_chk are compiled first.
`timescale 1ns/10ps
module testbench;
  logic sys_clk, rst_b, rx_strobe, key_valid, reinit_start, reinit_done;
  logic flow_enable, setup_toggle, disp_ready, disp_valid, tx_valid, tx_ready;
  logic click_enable, kbd_locked, slow, host_held;
  logic [6:0] rx_data, key_data, disp_data, tx_data;
  logic [8:0] rx_level;
  int num_errors, n_tests, n, m, r0;
  typedef struct {logic [6:0] c; logic [6:0] e;} srf_row_t;
  // Last row is a NUL fill character, which must pass like any other
  srf_row_t rows[5] = '{'{7'h41, 7'h41}, '{7'h7E, 7'h7E}, '{7'h01, 7'h01}, '{7'h5A, 7'h5A},
    '{7'h00, 7'h00}};
  srf_top u_srf_top (.sys_clk, .rst_b, .rx_data, .rx_strobe, .key_data, .key_valid,
    .reinit_start, .reinit_done, .flow_enable, .setup_toggle, .disp_ready, .disp_data,
    .disp_valid, .tx_data, .tx_valid, .tx_ready, .click_enable, .kbd_locked, .rx_level);
  srf_host u_srf_host (.sys_clk, .rst_b, .tx_data, .tx_valid, .tx_ready, .slow,
    .reinit_cmd(reinit_start), .held(host_held));
  // ----------------------------------------
  // Clock, tasks and watchdog
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // All stimulus lands 1 ns after the rising edge
  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(string nm, logic [9:0] seen, logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Idle lines show the inverse so a stale value never matches
  task automatic rx(logic [6:0] c);
    rx_data = c;
    rx_strobe = 1'b1;
    step;
    rx_strobe = 1'b0;
    rx_data = ~c;
    step;
  endtask
  task automatic key(logic [6:0] c);
    key_data = c;
    key_valid = 1'b1;
    step;
    key_valid = 1'b0;
    key_data = ~c;
    step;
  endtask
  // A char sent during the operation must be lost as well
  task automatic reinit;
    int r;
    r = u_srf_host.n_resume;
    rx(7'h44);
    reinit_start = 1'b1;
    step;
    reinit_start = 1'b0;
    rx(7'h45);
    chk("wipe", {disp_valid, rx_level}, 10'h000);
    reinit_done = 1'b1;
    step;
    reinit_done = 1'b0;
    for (int k = 0; k < 40 && u_srf_host.n_resume == r; k++) step;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Run takes about 2000 cycles; ten thousand means a hang
  initial begin
    #100000;
    num_errors++;
    end_sim;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_b, rx_strobe, key_valid, reinit_start, reinit_done, setup_toggle} = 6'h00;
    {rx_data, key_data, slow, flow_enable, disp_ready} = 17'h00003;
    {num_errors, n_tests} = 0;
    repeat (6) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    chk("idle", {disp_valid, tx_valid, kbd_locked, click_enable}, 10'h001);
    chk("idle_lvl", rx_level, 10'h000);
    // Ordinary characters pass straight through in order
    foreach (rows[i]) begin
      rx(rows[i].c);
      for (int k = 0; k < 5 && disp_valid !== 1'b1; k++) step;
      chk("disp", disp_data, rows[i].e);
    end
    // Stalled display, slow host that overruns on purpose
    // Let the last row's word be taken before the display stalls
    step;
    {disp_ready, slow, n} = 0;
    slow = 1'b1;
    while (rx_level !== srf_pkg::FULL_LEVEL && n < 300) begin
      rx(7'h20 + 7'(n % 64));
      n++;
    end
    repeat (3) rx(7'h7E);
    chk("full", rx_level, srf_pkg::FULL_LEVEL);
    chk("stops", 10'(u_srf_host.n_stop), 10'h001);
    disp_ready = 1'b1;
    m = 0;
    for (int k = 0; k < 800; k++) begin
      if (disp_valid === 1'b1) begin
        chk("order", disp_data, 7'h20 + 7'(m % 64));
        m++;
      end
      step;
    end
    chk("count", 10'(m), 10'(n));
    chk("resumes", 10'(u_srf_host.n_resume), 10'h001);
    // Keys wait while the host holds the terminal
    slow = 1'b0;
    rx(srf_pkg::CODE_STOP);
    key(7'h31);
    key(7'h32);
    repeat (8) step;
    chk("held", 10'(u_srf_host.keys.size()), 10'h000);
    rx(srf_pkg::CODE_RESUME);
    for (int k = 0; k < 40 && u_srf_host.keys.size() < 2; k++) step;
    chk("key0", u_srf_host.keys[0], 7'h31);
    chk("key1", u_srf_host.keys[1], 7'h32);
    chk("codes", rx_level, 10'h000);
    // Reinit while held, with and without flow control
    rx(srf_pkg::CODE_STOP);
    disp_ready = 1'b0;
    r0 = u_srf_host.n_resume;
    reinit;
    chk("resume", 10'(u_srf_host.n_resume - r0), 10'h001);
    flow_enable = 1'b0;
    reinit;
    chk("quiet", 10'(u_srf_host.n_resume - r0), 10'h001);
    flow_enable = 1'b1;
    // Overfill the key queue, then setup flushes it
    for (int i = 0; i < 256; i++) key(7'h40 + 7'(i % 32));
    chk("lock", {kbd_locked, click_enable}, 10'h002);
    setup_toggle = 1'b1;
    step;
    setup_toggle = 1'b0;
    step;
    chk("unlock", {kbd_locked, click_enable}, 10'h001);
    u_srf_host.keys.delete();
    rx(srf_pkg::CODE_RESUME);
    repeat (20) step;
    chk("flushed", 10'(u_srf_host.keys.size()), 10'h000);
    // Mid-run reset with a word in the slot and one in the buffer
    rx(7'h41);
    rx(7'h42);
    chk("before", rx_level, 10'h001);
    rst_b = 1'b0;
    repeat (2) step;
    rst_b = 1'b1;
    chk("reset", {disp_valid, tx_valid, kbd_locked, click_enable}, 10'h001);
    chk("reset_lvl", rx_level, 10'h000);
    end_sim;
  end
endmodule
bind srf_top srf_chk u_srf_chk (.sys_clk, .rst_b, .rx_data, .rx_strobe, .reinit_start,
  .flow_enable, .setup_toggle, .disp_ready, .disp_data, .disp_valid, .tx_data, .tx_valid,
  .tx_ready, .click_enable, .kbd_locked, .rx_level);
